// ---- hdl/twm_defs.vh ----
// register map, field positions, reset values, status codes and timing for the two-wire controller
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH
`define TWM_OFF_DIV 8'h00
`define TWM_OFF_CTL 8'h04
`define TWM_OFF_STAT 8'h08
`define TWM_OFF_DATA 8'h0C
`define TWM_OFF_ADR 8'h10
`define TWM_CTL_DONE 7
`define TWM_CTL_ACK 6
`define TWM_CTL_STA 5
`define TWM_CTL_STO 4
`define TWM_CTL_WC 3
`define TWM_CTL_EN 2
`define TWM_CTL_IE 0
`define TWM_RST_DIV 8'h00
`define TWM_RST_ADR 8'hFE
`define TWM_RST_PS 2'h0
`define TWM_GC_ADDR 8'h00
`define TWM_HALF_BASE 15'h0008
`define TWM_ST_NONE 8'hF8
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_MTA_ACK 8'h18
`define TWM_ST_MTA_NACK 8'h20
`define TWM_ST_MTD_ACK 8'h28
`define TWM_ST_MTD_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_MRA_ACK 8'h40
`define TWM_ST_MRA_NACK 8'h48
`define TWM_ST_MRD_ACK 8'h50
`define TWM_ST_MRD_NACK 8'h58
`define TWM_ST_SRA 8'h60
`define TWM_ST_SRA_ARB 8'h68
`define TWM_ST_GC 8'h70
`define TWM_ST_GC_ARB 8'h78
`define TWM_ST_SRD_ACK 8'h80
`define TWM_ST_SRD_NACK 8'h88
`define TWM_ST_GCD_ACK 8'h90
`define TWM_ST_GCD_NACK 8'h98
`define TWM_ST_SR_STOP 8'hA0
`define TWM_ST_STA 8'hA8
`define TWM_ST_STA_ARB 8'hB0
`define TWM_ST_STD_ACK 8'hB8
`define TWM_ST_STD_NACK 8'hC0
`define TWM_ST_STD_LAST 8'hC8
`endif

// ---- hdl/twm_ctrl.v ----
// two-wire serial controller: apb registers, bit-rate generator, master and slave byte engine
//
// Behaviour
// - master turns direction via repeated start
// - master seeing zero over its one loses
// - identical masters never see contention
// - arbitration lost in address: check own address
// - loser goes unaddressed or restarts when free
// - 8-bit divider sets scl rate, reset zero
// - done flag bit 7 set, scl held low except after a lost arbitration or a slave stop
// - done flag cleared by writing one only
// - irq while done, enable, global enable
// - ack bit 6 drives ack on matches
// - ack bit clear ignores own address
// - start bit 5 starts when bus free
// - stop bit 4 stops, self-clears after
// - stop as slave releases lines, unaddressed
// - data write while flag low: collision
// - enable bit 2 owns pins, off aborts
// - reserved control and status bits zero
// - status code in bits 7:3, read-only
// - prescaler 1, 4, 16 or 64
// - status reads no-info while flag clear
// - own address bit 0 enables general call
`timescale 1ns/1ps
`include "twm_defs.vh"
module twm_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire global_irq_enable,
  output reg irq,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n
);

  localparam M_IDLE = 3'd0;
  localparam M_S1 = 3'd1;
  localparam M_S2 = 3'd2;
  localparam M_S3 = 3'd3;
  localparam M_RUN = 3'd4;
  localparam M_P1 = 3'd5;
  localparam M_P2 = 3'd6;
  localparam M_P3 = 3'd7;

  reg [7:0] div;
  reg [1:0] ps;
  reg int_f, ea, sta, sto, wc, en, ie;
  reg [7:0] dat;
  reg [7:0] oar;
  reg [7:0] code;
  reg [2:0] scl_s, sda_s;
  reg scl_f, sda_f, scl_p, sda_p;
  reg [2:0] mst;
  reg master, listen, addressed, xmit, is_addr, rep, arb_lost;
  reg ack_sent, ack_rx, drop, gc_hit, last_tx, busy, go;
  reg [3:0] bit_cnt;
  reg [7:0] sh;
  reg [14:0] tmr;
  reg [7:0] rd_mux;

  // half scl period; prescale is a left shift by 0, 2, 4 or 6
  wire [14:0] half = `TWM_HALF_BASE + ({7'h00, div} << {ps, 1'b0});
  wire half_done = (tmr == half);
  wire acc = psel & penable & ~pready;
  wire mapped = (paddr == `TWM_OFF_DIV) | (paddr == `TWM_OFF_CTL) | (paddr == `TWM_OFF_STAT) |
                (paddr == `TWM_OFF_DATA) | (paddr == `TWM_OFF_ADR);
  wire scl_rise = scl_f & ~scl_p;
  wire scl_fall = ~scl_f & scl_p;
  wire start_det = scl_f & scl_p & sda_p & ~sda_f;
  wire stop_det = scl_f & scl_p & ~sda_p & sda_f;
  wire eng = ~int_f & ((master & (mst == M_RUN)) | listen | addressed);
  wire tx_role = is_addr ? master : xmit;
  wire addr_me = (sh[7:1] == oar[7:1]);
  wire gc_ok = oar[0] & (sh == `TWM_GC_ADDR);
  wire addr_hit = ea & (addr_me | gc_ok);
  // the no-info code only shows its upper five bits, the rest of the byte is reserved and prescaler
  wire [7:0] none_code = `TWM_ST_NONE;
  wire [4:0] stat_code = int_f ? code[7:3] : none_code[7:3];

  always @* begin
    case (paddr)
      `TWM_OFF_DIV: rd_mux = div;
      `TWM_OFF_CTL: rd_mux = {int_f, ea, sta, sto, wc, en, 1'b0, ie};
      `TWM_OFF_STAT: rd_mux = {stat_code, 1'b0, ps};
      `TWM_OFF_DATA: rd_mux = dat;
      `TWM_OFF_ADR: rd_mux = oar;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      div <= `TWM_RST_DIV;
      ps <= `TWM_RST_PS;
      int_f <= 1'b0;
      ea <= 1'b0;
      sta <= 1'b0;
      sto <= 1'b0;
      wc <= 1'b0;
      en <= 1'b0;
      ie <= 1'b0;
      dat <= 8'hFF;
      oar <= `TWM_RST_ADR;
      code <= `TWM_ST_NONE;
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      mst <= M_IDLE;
      master <= 1'b0;
      listen <= 1'b0;
      addressed <= 1'b0;
      xmit <= 1'b0;
      is_addr <= 1'b0;
      rep <= 1'b0;
      arb_lost <= 1'b0;
      ack_sent <= 1'b0;
      ack_rx <= 1'b0;
      drop <= 1'b0;
      gc_hit <= 1'b0;
      last_tx <= 1'b0;
      busy <= 1'b0;
      go <= 1'b0;
      bit_cnt <= 4'h0;
      sh <= 8'hFF;
      tmr <= 15'h0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      go <= 1'b0;
      irq <= int_f & ie & global_irq_enable;
      // three-stage pin sampling; a level counts once the last two stages agree (spike filter)
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
      scl_p <= scl_f;
      sda_p <= sda_f;

      if (acc) begin
        pslverr <= ~mapped;
        if (!pwrite) begin
          prdata <= {24'h000000, rd_mux};
        end else begin
          case (paddr)
            `TWM_OFF_DIV: div <= pwdata[7:0];
            `TWM_OFF_CTL: begin
              ea <= pwdata[`TWM_CTL_ACK];
              sta <= pwdata[`TWM_CTL_STA];
              sto <= pwdata[`TWM_CTL_STO];
              en <= pwdata[`TWM_CTL_EN];
              ie <= pwdata[`TWM_CTL_IE];
              // a one clears the flag and lets the engine move on next cycle
              if (pwdata[`TWM_CTL_DONE] && int_f) begin
                int_f <= 1'b0;
                go <= 1'b1;
              end
            end
            `TWM_OFF_STAT: ps <= pwdata[1:0];
            `TWM_OFF_DATA: begin
              wc <= ~int_f;
              if (int_f) dat <= pwdata[7:0];
            end
            `TWM_OFF_ADR: oar <= pwdata[7:0];
            default: ;
          endcase
        end
      end

      if (!en) begin
        // switching off drops everything mid-transfer and lets go of both lines
        mst <= M_IDLE;
        master <= 1'b0;
        listen <= 1'b0;
        addressed <= 1'b0;
        busy <= 1'b0;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
        tmr <= 15'h0000;
      end else begin
        if (start_det) begin
          busy <= 1'b1;
          bit_cnt <= 4'h0;
          is_addr <= 1'b1;
          sh <= 8'hFF;
          if (!master) begin
            listen <= 1'b1;
            addressed <= 1'b0;
            arb_lost <= 1'b0;
            sda_oe_n <= 1'b1;
          end
        end
        if (stop_det) begin
          busy <= 1'b0;
          listen <= 1'b0;
          addressed <= 1'b0;
          sda_oe_n <= 1'b1;
          if (addressed && !int_f) begin
            int_f <= 1'b1;
            code <= `TWM_ST_SR_STOP;
          end
        end

        if (go) begin
          if (sto) begin
            if (master) begin
              mst <= M_P1;
              tmr <= 15'h0000;
            end else begin
              // slave recovery: no stop on the bus, just let go
              sto <= 1'b0;
              addressed <= 1'b0;
              listen <= 1'b0;
              scl_oe_n <= 1'b1;
              sda_oe_n <= 1'b1;
            end
          end else if (sta && master) begin
            mst <= M_S1;
            rep <= 1'b1;
            tmr <= 15'h0000;
          end else if (drop && !master) begin
            addressed <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
          end else if (master || addressed) begin
            sh <= (is_addr | xmit) ? dat : 8'hFF;
            sda_oe_n <= ~((is_addr | xmit) & ~dat[7]);
            last_tx <= ~ea;
            tmr <= 15'h0000;
            if (!master) scl_oe_n <= 1'b1;
          end
          drop <= 1'b0;
        end

        case (mst)
          M_IDLE: begin
            // start waits for a free bus; busy drops on a stop or when enable is cleared
            if (sta && !master && !int_f && !busy && !addressed && !listen) begin
              mst <= M_S1;
              master <= 1'b1;
              rep <= 1'b0;
              tmr <= 15'h0000;
            end
          end
          M_S1: begin
            sda_oe_n <= 1'b1;
            if (half_done) begin
              scl_oe_n <= 1'b1;
              tmr <= 15'h0000;
              mst <= M_S2;
            end else tmr <= tmr + 15'h0001;
          end
          M_S2: begin
            if (!scl_f || !sda_f) tmr <= 15'h0000;
            else if (half_done) begin
              sda_oe_n <= 1'b0;
              tmr <= 15'h0000;
              mst <= M_S3;
            end else tmr <= tmr + 15'h0001;
          end
          M_S3: begin
            if (half_done) begin
              scl_oe_n <= 1'b0;
              tmr <= 15'h0000;
              mst <= M_RUN;
              int_f <= 1'b1;
              code <= rep ? `TWM_ST_RSTART : `TWM_ST_START;
              is_addr <= 1'b1;
              bit_cnt <= 4'h0;
            end else tmr <= tmr + 15'h0001;
          end
          M_RUN: begin
            // high phase is timed from the seen level, so a stretching slave slows us
            if (!int_f) begin
              if (!scl_oe_n) begin
                if (half_done) begin
                  scl_oe_n <= 1'b1;
                  tmr <= 15'h0000;
                end else tmr <= tmr + 15'h0001;
              end else if (!scl_f) tmr <= 15'h0000;
              else if (half_done) begin
                scl_oe_n <= 1'b0;
                tmr <= 15'h0000;
              end else tmr <= tmr + 15'h0001;
            end
          end
          M_P1: begin
            sda_oe_n <= 1'b0;
            if (half_done) begin
              scl_oe_n <= 1'b1;
              tmr <= 15'h0000;
              mst <= M_P2;
            end else tmr <= tmr + 15'h0001;
          end
          M_P2: begin
            if (!scl_f) tmr <= 15'h0000;
            else if (half_done) begin
              sda_oe_n <= 1'b1;
              tmr <= 15'h0000;
              mst <= M_P3;
            end else tmr <= tmr + 15'h0001;
          end
          M_P3: begin
            if (half_done) begin
              mst <= M_IDLE;
              master <= 1'b0;
              sto <= 1'b0;
            end else tmr <= tmr + 15'h0001;
          end
          default: mst <= M_IDLE;
        endcase

        if (eng && scl_rise) begin
          if (bit_cnt != 4'h8) begin
            sh <= {sh[6:0], sda_f};
            // only a driven one read back as zero loses; equal bits never collide
            if (master && tx_role && sh[7] && !sda_f) begin
              master <= 1'b0;
              arb_lost <= 1'b1;
              listen <= 1'b1;
              mst <= M_IDLE;
              scl_oe_n <= 1'b1;
              sda_oe_n <= 1'b1;
            end
          end else ack_rx <= ~sda_f;
        end

        if (eng && scl_fall) begin
          if (bit_cnt == 4'h7) begin
            bit_cnt <= 4'h8;
            if (is_addr && !master) begin
              ack_sent <= addr_hit;
              sda_oe_n <= ~addr_hit;
            end else if (!tx_role && (master || addressed)) begin
              ack_sent <= ea;
              sda_oe_n <= ~ea;
            end else begin
              ack_sent <= 1'b0;
              sda_oe_n <= 1'b1;
            end
          end else if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            is_addr <= 1'b0;
            sda_oe_n <= 1'b1;
            if (master) begin
              int_f <= 1'b1;
              scl_oe_n <= 1'b0;
              if (is_addr) begin
                xmit <= ~sh[0];
                if (sh[0]) code <= ack_rx ? `TWM_ST_MRA_ACK : `TWM_ST_MRA_NACK;
                else code <= ack_rx ? `TWM_ST_MTA_ACK : `TWM_ST_MTA_NACK;
              end else if (xmit) code <= ack_rx ? `TWM_ST_MTD_ACK : `TWM_ST_MTD_NACK;
              else begin
                dat <= sh;
                code <= ack_sent ? `TWM_ST_MRD_ACK : `TWM_ST_MRD_NACK;
              end
            end else if (addressed) begin
              int_f <= 1'b1;
              scl_oe_n <= 1'b0;
              if (xmit) begin
                code <= !ack_rx ? `TWM_ST_STD_NACK : (last_tx ? `TWM_ST_STD_LAST : `TWM_ST_STD_ACK);
                drop <= ~ack_rx | last_tx;
              end else begin
                dat <= sh;
                if (gc_hit) code <= ack_sent ? `TWM_ST_GCD_ACK : `TWM_ST_GCD_NACK;
                else code <= ack_sent ? `TWM_ST_SRD_ACK : `TWM_ST_SRD_NACK;
                drop <= ~ack_sent;
              end
            end else if (listen) begin
              listen <= 1'b0;
              arb_lost <= 1'b0;
              if (is_addr && ack_sent) begin
                addressed <= 1'b1;
                int_f <= 1'b1;
                scl_oe_n <= 1'b0;
                xmit <= sh[0];
                gc_hit <= (sh == `TWM_GC_ADDR);
                if (sh[0]) code <= arb_lost ? `TWM_ST_STA_ARB : `TWM_ST_STA;
                else if (sh == `TWM_GC_ADDR) code <= arb_lost ? `TWM_ST_GC_ARB : `TWM_ST_GC;
                else code <= arb_lost ? `TWM_ST_SRA_ARB : `TWM_ST_SRA;
              end else if (arb_lost) begin
                // software now picks: clear to stay unaddressed, or set start for a retry
                int_f <= 1'b1;
                code <= `TWM_ST_ARB;
              end
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            sda_oe_n <= ~((master || addressed) & tx_role & ~sh[7]);
          end
        end
      end
    end
  end

endmodule // twm_ctrl

// ---- bench/twm_sva.sv ----
// assertions on the apb and pin ports of the two-wire controller
`timescale 1ns/1ps
module twm_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic irq,
  input wire logic scl_out,
  input wire logic sda_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held past one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("access not answered in time");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable)) else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr outside answer cycle");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits not zero");
  a_ctl_rsvd: assert property (pready && !pwrite && paddr == 8'h04 |-> !prdata[1]) else $error("control bit 1 set");
  a_stat_rsvd: assert property (pready && !pwrite && paddr == 8'h08 |-> !prdata[2]) else $error("state bit 2 set");
  a_irq_mask: assert property (!$past(global_irq_enable) |-> !irq) else $error("irq while globally masked");
  // the pins are open drain: only the enables may carry a level
  a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0) else $error("pin data not zero");
endmodule // twm_sva
bind twm_ctrl twm_sva twm_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .irq(irq), .scl_out(scl_out), .sda_out(sda_out));

// ---- bench/twm_bus_model.sv ----
// behavioural slave on the two-wire bus: acks its address with the write bit and the written bytes
`timescale 1ns/1ps
module twm_bus_model #(parameter logic [6:0] ADDR = 7'h52) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n,
  output logic [7:0] last_byte
);
  logic [7:0] sh;
  int bitc;
  logic active, first, hit;
  initial begin
    sda_oe_n = 1'b1;
    last_byte = 8'h00;
    sh = 8'h00;
    active = 1'b0;
    first = 1'b0;
    hit = 1'b0;
    bitc = 0;
  end
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    first = 1'b1;
    bitc = 0;
  end
  always @(posedge sda) if (scl) active = 1'b0;
  always @(posedge scl) if (active && bitc < 8) begin
    sh = {sh[6:0], sda};
    bitc++;
  end
  // read requests are never acked, so the model never has to drive data bits
  always @(negedge scl) if (active) begin
    if (bitc == 9) begin
      sda_oe_n <= 1'b1;
      bitc = 0;
    end else if (bitc == 8) begin
      if (first) hit = (sh[7:1] == ADDR) && !sh[0];
      else if (hit) last_byte = sh;
      first = 1'b0;
      bitc = 9;
      if (hit) sda_oe_n <= 1'b0;
    end
  end
endmodule // twm_bus_model

// ---- bench/tb_top.sv ----
// testbench: apb register checks and bus transfers against a slave model
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, global_irq_enable, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, irq, scl_out, scl_oe_n, sda_out, sda_oe_n, m_sda_oe_n;
  wire [7:0] m_byte;
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & m_sda_oe_n;
  int err_total, compares;
  twm_ctrl twm_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  twm_bus_model #(.ADDR(7'h52)) twm_bus_model_i (.scl(scl), .sda(sda), .sda_oe_n(m_sda_oe_n), .last_byte(m_byte));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic results;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle cycle after each transfer keeps every signal to one assignment per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin err_total++; results; end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task automatic rg(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic wait_ctl(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin rg(8'h04); n++; end while ((rd[7:0] & m) !== v && n < 400);
    if ((rd[7:0] & m) !== v) begin err_total++; results; end
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; global_irq_enable = 1'b0; rd = 32'h0; err_seen = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rg(8'h00); chk(rd, 32'h00);
    rg(8'h04); chk(rd, 32'h00);
    rg(8'h08); chk(rd, 32'hF8);
    rg(8'h14); chk({rd[31:1], err_seen}, 32'h1);
    wr(8'h00, 8'h5A); rg(8'h00); chk(rd, 32'h5A);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'hFF); rg(8'h08); chk(rd, 32'hFB);
    wr(8'h0C, 8'h11); rg(8'h04); chk(rd, 32'h08);
    global_irq_enable <= 1'b1;
    wr(8'h04, 8'h25); wait_ctl(8'h80, 8'h80);
    rg(8'h08); chk(rd & 32'hF8, 32'h08);
    chk({30'h0, irq, scl}, 32'h2);
    wr(8'h0C, 8'hA4); rg(8'h04); chk(rd, 32'hA5);
    wr(8'h04, 8'h85); wait_ctl(8'h80, 8'h80);
    rg(8'h08); chk(rd & 32'hF8, 32'h18);
    wr(8'h0C, 8'h3C); wr(8'h04, 8'h05); rg(8'h04); chk(rd, 32'h85);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    global_irq_enable <= 1'b1;
    wr(8'h04, 8'h85); wait_ctl(8'h80, 8'h80);
    rg(8'h08); chk(rd & 32'hF8, 32'h28);
    chk({24'h0, m_byte}, 32'h3C);
    wr(8'h04, 8'hA5); wait_ctl(8'h80, 8'h80);
    rg(8'h08); chk(rd & 32'hF8, 32'h10);
    wr(8'h0C, 8'h63); wr(8'h04, 8'h85); wait_ctl(8'h80, 8'h80);
    rg(8'h08); chk(rd & 32'hF8, 32'h48);
    wr(8'h04, 8'h95); wait_ctl(8'h10, 8'h00);
    rg(8'h04); chk(rd, 32'h05);
    rg(8'h08); chk(rd & 32'hF8, 32'hF8);
    wr(8'h04, 8'h24); wait_ctl(8'h80, 8'h80);
    wr(8'h04, 8'h00);
    repeat (2) @(posedge pclk);
    chk({30'h0, scl, sda}, 32'h3);
    results;
  end
endmodule // tb_top
